// ===== src/sse_interlock.sv
// Shutter status contacts, emergency stop and remote interlock top
//
// Function
// - A closed timesharing select drives the matching timesharing unit to route light.
// - Timesharing selects count only while branch shutters are under independent control and the stop sequence is in its run state.
// - The resonator status contact is closed exactly while the resonator shutter is open.
// - Each branch status contact is closed exactly while its branch shutter is open.
// - Each timesharing status contact is closed exactly while its unit is operated.
// - An open emergency stop loop puts the block in a stop state that halts the laser.
// - The emergency stop output contact is open whenever a stop is in effect.
// - An open interlock loop closes all shutters and stops guide light and laser.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_interlock
  import sse_pkg::*;
#(
  parameter int FILT_CYC = `SSE_FILT_CYC
) (
  input  logic          clk_sys_in,
  input  logic          reset_in,
  input  sse_avmm_req_t avs_req_in,
  output sse_avmm_rsp_t avs_rsp_out,
  input  sse_loops_t    loops_in,
  output logic          res_shutter_out,
  output logic [3:0]    branch_shutter_out,
  output logic [2:0]    ts_unit_out,
  output logic          guide_light_out,
  output logic          laser_enable_out,
  output logic          res_open_contact_out,
  output logic [3:0]    branch_open_contact_out,
  output logic [2:0]    ts_on_contact_out,
  output logic          estop_contact_out,
  output logic          irq_out
);

  // ============================================================
  // Declarations
  sse_top_st_t          st_r;
  sse_top_st_t          st_nxt;
  sse_est_t             est_nxt;
  sse_loops_t           filt;
  logic [4:0]           filt_vec;
  logic [`SSE_EV_W-1:0] evt;
  logic [`SSE_EV_W-1:0] irq_stat;
  logic                 req;
  logic                 acc;
  logic                 wr_acc;
  logic                 rd_clr;
  logic                 rearm_wr;
  logic                 run_n;
  logic                 off_all;
  logic                 ilk_open;

  // ============================================================
  // Helpers
  // Address decode shared by read and write paths
  function automatic logic hit(input logic [`SSE_ADDR_W-1:0] a,
                               input logic [`SSE_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Read mux, unmapped addresses read as zero
  function automatic logic [`SSE_DATA_W-1:0] rd_mux(
    input logic [`SSE_ADDR_W-1:0] a,
    input sse_top_st_t            s,
    input logic [`SSE_EV_W-1:0]   ist
  );
    rd_mux = '0;
    if (hit(a, `SSE_OFS_CTRL)) begin
      rd_mux = `SSE_DATA_W'(s.ctrl);
    end else if (hit(a, `SSE_OFS_STAT)) begin
      rd_mux = `SSE_DATA_W'({s.est, s.ilk_q, s.ts, s.br, s.res});
    end else if (hit(a, `SSE_OFS_IRQ)) begin
      rd_mux = `SSE_DATA_W'(ist);
    end else if (hit(a, `SSE_OFS_MASK)) begin
      rd_mux = `SSE_DATA_W'(s.mask);
    end
  endfunction

  // ============================================================
  // Input conditioning
  // Loops power up treated as open, so the block starts safe
  sse_filt #(
    .W   (5),
    .CYC (FILT_CYC),
    .RST (5'h00)
  ) u_filt (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .raw_in     (loops_in),
    .q_out      (filt_vec)
  );
  assign filt = sse_loops_t'(filt_vec);

  // ============================================================
  // Bus handshake terms
  // One wait cycle per access; read data is captured in it
  assign req      = avs_req_in.read | avs_req_in.write;
  assign acc      = req & ~st_r.waitreq;
  assign wr_acc   = acc & avs_req_in.write;
  assign rd_clr   = acc & avs_req_in.read & hit(avs_req_in.address, `SSE_OFS_IRQ);
  assign rearm_wr = wr_acc & hit(avs_req_in.address, `SSE_OFS_CMD)
                    & avs_req_in.writedata[`SSE_CMD_REARM];

  // ============================================================
  // Safety terms
  assign ilk_open = ~filt.ilk_closed;
  assign run_n    = (est_nxt == est_run);
  assign off_all  = ~run_n | ilk_open;

  // ============================================================
  // Stop sequence
  // stop on open loop
  // Restart needs both a closed loop and a software rearm,
  // like turning the key back on after a stop; kept apart from
  // the main next-state process so the safety terms never loop
  always_comb begin
    est_nxt = st_r.est;
    case (st_r.est)
      est_run: begin
        if (!filt.estop_closed) begin
          est_nxt = est_stop;
        end
      end
      est_stop: begin
        if (filt.estop_closed) begin
          est_nxt = est_rearm;
        end
      end
      est_rearm: begin
        if (!filt.estop_closed) begin
          est_nxt = est_stop;
        end else if (rearm_wr) begin
          est_nxt = est_run;
        end
      end
      default: begin
        est_nxt = est_stop;
      end
    endcase
    if (reset_in) begin
      est_nxt = est_stop;
    end
  end

  // ============================================================
  // Next state
  always_comb begin
    st_nxt = st_r;

    // Register writes land at the edge that completes the access
    if (wr_acc && hit(avs_req_in.address, `SSE_OFS_CTRL)) begin
      st_nxt.ctrl = sse_ctrl_t'(avs_req_in.writedata[$bits(sse_ctrl_t)-1:0]);
    end
    if (wr_acc && hit(avs_req_in.address, `SSE_OFS_MASK)) begin
      st_nxt.mask = avs_req_in.writedata[`SSE_EV_W-1:0];
    end

    // Waitrequest drops for one cycle after a request is seen
    st_nxt.waitreq = ~(req & st_r.waitreq);
    // Events landing now are read too, so the later clear loses none
    if (req && st_r.waitreq) begin
      st_nxt.rdata = rd_mux(avs_req_in.address, st_r, irq_stat | evt);
    end

    // stop state from its own process
    st_nxt.est = est_nxt;

    st_nxt.ilk_q = ilk_open;

    // interlock forces all closed
    // Shutters, guide and laser follow software only while safe
    st_nxt.res   = st_r.ctrl.res & ~off_all;
    st_nxt.br    = st_r.ctrl.br & {4{~off_all}};
    st_nxt.guide = st_r.ctrl.guide & ~off_all;
    st_nxt.laser = st_r.ctrl.laser & ~off_all;

    st_nxt.ts = (st_r.ctrl.indep && run_n) ? filt.ts_sel : 3'h0;

    st_nxt.est_ct = run_n;

    if (reset_in) begin
      st_nxt         = '0;
      st_nxt.est     = est_stop;
      st_nxt.mask    = `SSE_MASK_RST;
      st_nxt.waitreq = 1'b1;
      st_nxt.ilk_q   = 1'b1; // Loop seen open out of reset, no false edge
    end
  end

  // Register
  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  // ============================================================
  // Events and interrupt
  // Edges of the stop sequence and of the interlock loop
  always_comb begin
    evt                = '0;
    evt[`SSE_EV_ESTOP] = (est_nxt == est_stop) & (st_r.est != est_stop);
    evt[`SSE_EV_ILK]   = ilk_open & ~st_r.ilk_q;
    evt[`SSE_EV_REST]  = (est_nxt == est_rearm) & (st_r.est == est_stop);
    if (reset_in) begin
      evt = '0;
    end
  end

  sse_irq #(
    .N (`SSE_EV_W)
  ) u_irq (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .evt_in     (evt),
    .clr_in     (rd_clr),
    .mask_in    (st_r.mask),
    .stat_out   (irq_stat),
    .irq_out    (irq_out)
  );

  // ============================================================
  // Outputs, all straight from flops
  // resonator contact mirrors shutter
  // unit contacts mirror drives
  // Contacts share the drive flops, so they cannot disagree
  assign avs_rsp_out.readdata    = st_r.rdata;
  assign avs_rsp_out.waitrequest = st_r.waitreq;
  assign res_shutter_out         = st_r.res;
  assign branch_shutter_out      = st_r.br;
  assign ts_unit_out             = st_r.ts;
  assign guide_light_out         = st_r.guide;
  assign laser_enable_out        = st_r.laser;
  assign res_open_contact_out    = st_r.res;
  assign branch_open_contact_out = st_r.br;
  assign ts_on_contact_out       = st_r.ts;
  assign estop_contact_out       = st_r.est_ct;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  property p_ts_route;
    (run_n && st_r.ctrl.indep) |=> (ts_unit_out == $past(filt.ts_sel));
  endproperty
  a_ts_route: assert property (p_ts_route)
    else $error("timesharing unit does not follow its select");

  property p_ts_gate;
    (!st_r.ctrl.indep) |=> (ts_unit_out == 3'h0);
  endproperty
  a_ts_gate: assert property (p_ts_gate)
    else $error("timesharing unit moved outside independent mode");

  property p_res_contact;
    res_open_contact_out |-> ($past(st_r.ctrl.res) && $past(run_n) && $past(!ilk_open));
  endproperty
  a_res_contact: assert property (p_res_contact)
    else $error("resonator contact closed without an open shutter");

  property p_br_contact;
    ##1 (branch_open_contact_out == ($past(st_r.ctrl.br) & {4{$past(!off_all)}}));
  endproperty
  a_br_contact: assert property (p_br_contact)
    else $error("branch contact disagrees with shutter");

  property p_ts_contact;
    (ts_on_contact_out != 3'h0) |-> ($past(st_r.ctrl.indep) && $past(run_n));
  endproperty
  a_ts_contact: assert property (p_ts_contact)
    else $error("timesharing contact closed while unit idle");

  property p_estop_halt;
    (st_r.est == est_run && !filt.estop_closed)
      |=> (st_r.est == est_stop) && !laser_enable_out && !res_shutter_out;
  endproperty
  a_estop_halt: assert property (p_estop_halt)
    else $error("open stop loop did not halt the laser");

  property p_estop_contact;
    (!filt.estop_closed) |=> (!estop_contact_out)[*2];
  endproperty
  a_estop_contact: assert property (p_estop_contact)
    else $error("stop output contact closed during a stop");

  property p_ilk_close;
    ilk_open |=> (!res_shutter_out && branch_shutter_out == 4'h0
                  && !guide_light_out && !laser_enable_out);
  endproperty
  a_ilk_close: assert property (p_ilk_close)
    else $error("interlock open but light path still live");

  property p_bus_answer;
    (req && st_r.waitreq) |=> !avs_rsp_out.waitrequest ##1 avs_rsp_out.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not after exactly one wait cycle");

  property p_rd_irq;
    (req && st_r.waitreq && hit(avs_req_in.address, `SSE_OFS_IRQ))
      |=> (avs_rsp_out.readdata[`SSE_EV_W-1:0] == irq_stat);
  endproperty
  a_rd_irq: assert property (p_rd_irq)
    else $error("interrupt status read missed a pending event");

  property p_evt_sticky;
    (|evt) |=> ((irq_stat & $past(evt)) == $past(evt));
  endproperty
  a_evt_sticky: assert property (p_evt_sticky)
    else $error("event lost against a status clear");

  property p_irq_level;
    1'b1 |=> (irq_out == |(irq_stat & $past(st_r.mask)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with status and mask");

  property p_rearm_gate;
    (st_r.est == est_stop) |=> (st_r.est != est_run);
  endproperty
  a_rearm_gate: assert property (p_rearm_gate)
    else $error("stop state left straight for run");

  property p_estop_ct_run;
    estop_contact_out == (st_r.est == est_run);
  endproperty
  a_estop_ct_run: assert property (p_estop_ct_run)
    else $error("stop output contact disagrees with the stop state");

  property p_ctrl_write;
    (wr_acc && hit(avs_req_in.address, `SSE_OFS_CTRL))
      |=> (st_r.ctrl == $past(avs_req_in.writedata[$bits(sse_ctrl_t)-1:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");

  c_estop_trip: cover property (st_r.est == est_run ##1 st_r.est == est_stop);
  c_ilk_open: cover property ($rose(st_r.ilk_q));
  c_ts_on: cover property (ts_unit_out != 3'h0);
  c_rearm: cover property (st_r.est == est_rearm ##1 st_r.est == est_run);

endmodule

// ===== src/sse_params.svh
// Constants for the shutter status, emergency stop and interlock block
`ifndef SSE_PARAMS_SVH
`define SSE_PARAMS_SVH

// ============================================================
// Clock and filter timing
`define SSE_CLK_MHZ      200
`define SSE_FILT_NS      10000
`define SSE_FILT_CYC     ((`SSE_FILT_NS * `SSE_CLK_MHZ) / 1000)

// ============================================================
// Bus geometry and register byte offsets
`define SSE_ADDR_W       8
`define SSE_DATA_W       32
`define SSE_OFS_CTRL     8'h00
`define SSE_OFS_CMD      8'h04
`define SSE_OFS_STAT     8'h08
`define SSE_OFS_IRQ      8'h0c
`define SSE_OFS_MASK     8'h10

// ============================================================
// Field positions, encodings and reset values
`define SSE_CMD_REARM    0
`define SSE_EV_W         3
`define SSE_EV_ESTOP     0
`define SSE_EV_ILK       1
`define SSE_EV_REST      2
`define SSE_EST_STOP     2'h0
`define SSE_EST_REARM    2'h1
`define SSE_EST_RUN      2'h3
`define SSE_MASK_RST     3'h0

`endif

// ===== src/sse_pkg.sv
// Types shared by the shutter status, emergency stop and interlock block
package sse_pkg;
`include "sse_params.svh"

  // Emergency stop sequence, Gray along stop, rearm, run
  typedef enum logic [1:0] {
    est_stop  = `SSE_EST_STOP,
    est_rearm = `SSE_EST_REARM,
    est_run   = `SSE_EST_RUN
  } sse_est_t;

  // Software control word
  typedef struct packed {
    logic       laser;
    logic       guide;
    logic       indep;
    logic [3:0] br;
    logic       res;
  } sse_ctrl_t;

  // Avalon-MM request and answer
  typedef struct packed {
    logic [`SSE_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [`SSE_DATA_W-1:0] writedata;
  } sse_avmm_req_t;

  typedef struct packed {
    logic [`SSE_DATA_W-1:0] readdata;
    logic                   waitrequest;
  } sse_avmm_rsp_t;

  // Contact inputs, high means the loop or contact is closed
  typedef struct packed {
    logic       estop_closed;
    logic       ilk_closed;
    logic [2:0] ts_sel;
  } sse_loops_t;

  // Whole state of the top module
  typedef struct packed {
    sse_ctrl_t              ctrl;
    logic [`SSE_EV_W-1:0]   mask;
    sse_est_t               est;
    logic                   ilk_q;
    logic                   waitreq;
    logic [`SSE_DATA_W-1:0] rdata;
    logic                   res;
    logic [3:0]             br;
    logic [2:0]             ts;
    logic                   guide;
    logic                   laser;
    logic                   est_ct;
  } sse_top_st_t;

endpackage

// ===== src/sse_filt.sv
// Input synchroniser and contact bounce filter
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_filt
  import sse_pkg::*;
#(
  parameter int           W   = 5,
  parameter int           CYC = `SSE_FILT_CYC,
  parameter logic [W-1:0] RST = '0
) (
  input  logic         clk_sys_in,
  input  logic         reset_in,
  input  logic [W-1:0] raw_in,
  output logic [W-1:0] q_out
);
  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0]         s1;
    logic [W-1:0]         s2;
    logic [W-1:0]         q;
    logic [W-1:0][CW-1:0] cnt;
  } sse_filt_st_t;

  sse_filt_st_t st_r;
  sse_filt_st_t st_nxt;
  logic [W-1:0] hit;

  // ============================================================
  // Next state
  // Output follows only after a full quiet interval
  always_comb begin
    st_nxt = st_r;
    hit    = '0;
    st_nxt.s1 = raw_in;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.q[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] == CW'(CYC - 1)) begin
        st_nxt.q[i]   = st_r.s2[i];
        st_nxt.cnt[i] = '0;
        hit[i]        = 1'b1;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
      end
    end
    if (reset_in) begin
      st_nxt   = '0;
      st_nxt.q = RST;
    end
  end

  // Register
  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  assign q_out = st_r.q;

  // ============================================================
  // Checks
  property p_filt_settle;
    @(posedge clk_sys_in) disable iff (reset_in)
      (st_r.q != $past(st_r.q)) |-> ($past(|hit) && ($past(st_r.s2, 2) == $past(st_r.s2)));
  endproperty
  a_filt_settle: assert property (p_filt_settle)
    else $error("filtered input moved without a settled sample");

endmodule

// ===== src/sse_irq.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_irq
  import sse_pkg::*;
#(
  parameter int N = `SSE_EV_W
) (
  input  logic         clk_sys_in,
  input  logic         reset_in,
  input  logic [N-1:0] evt_in,
  input  logic         clr_in,
  input  logic [N-1:0] mask_in,
  output logic [N-1:0] stat_out,
  output logic         irq_out
);
  typedef struct packed {
    logic [N-1:0] stat;
    logic         irq;
  } sse_irq_st_t;

  sse_irq_st_t st_r;
  sse_irq_st_t st_nxt;

  // ============================================================
  // Set wins over a read clear in the same cycle
  always_comb begin
    st_nxt      = st_r;
    st_nxt.stat = (clr_in ? '0 : st_r.stat) | evt_in;
    st_nxt.irq  = |(st_nxt.stat & mask_in);
    if (reset_in) begin
      st_nxt = '0;
    end
  end

  // Register
  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  assign stat_out = st_r.stat;
  assign irq_out  = st_r.irq;

  c_irq_fire: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(irq_out));

endmodule

// ===== dv/sse_plc_model.sv
// Far side model: controller select contacts and safety loops with chatter
`timescale 1ns/1ps
module sse_plc_model
  import sse_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       estop_req_in,
  input  wire logic       ilk_req_in,
  input  wire logic [2:0] ts_req_in,
  input  wire logic [1:0] bounce_in,
  output sse_loops_t      loops_out
);
  // ============================================================
  // Contact state
  sse_loops_t want;
  sse_loops_t last_r = '0;
  sse_loops_t chg_r  = '0;
  logic [1:0] left_r = 2'h0;

  assign want = '{estop_closed: estop_req_in, ilk_closed: ilk_req_in, ts_sel: ts_req_in};

  // Changed contacts chatter a few edges, real switches never land cleanly
  always @(posedge clk_sys_in) begin
    last_r <= want;
    if (want != last_r) begin
      chg_r <= want ^ last_r;
      left_r <= bounce_in;
    end else if (left_r != 2'h0) begin
      left_r <= left_r - 2'h1;
    end
    loops_out <= (left_r != 2'h0) ? (loops_out ^ chg_r) : want;
  end
endmodule

// ===== dv/sse_interlock_tb.sv
// Self-checking bench for the shutter status, stop and interlock block
`timescale 1ns/1ps
module sse_interlock_tb;
  import sse_pkg::*;
  // Short filter keeps the run brief; waits derive from it
  localparam int FILT   = 8;
  localparam int SETTLE = FILT + 12;

  // ============================================================
  // Signals
  logic          clk_sys_in = 1'b0;
  logic          reset_in   = 1'b1;
  sse_avmm_req_t req        = '0;
  sse_avmm_rsp_t rsp;
  sse_loops_t    loops;
  logic          res_s, res_c, guide, laser, estop_c, irq;
  logic [3:0]    br_s, br_c;
  logic [2:0]    ts_s, ts_c, t;
  logic          samp      = 1'b0;
  logic          estop_req = 1'b0;
  logic          ilk_req   = 1'b0;
  logic [2:0]    ts_req    = 3'h0;
  logic [1:0]    bounce    = 2'h0;
  int            fails       = 0;
  int            checks_done = 0;
  int            seed        = 32'h484b;
  logic [31:0]   rq[$];
  logic [31:0]   rm[$];
  logic [12:0]   oq[$];
  logic [31:0]   m_r;

  always #2.5 clk_sys_in = ~clk_sys_in;

  sse_interlock #(.FILT_CYC(FILT)) dut (
    .clk_sys_in              (clk_sys_in),
    .reset_in                (reset_in),
    .avs_req_in              (req),
    .avs_rsp_out             (rsp),
    .loops_in                (loops),
    .res_shutter_out         (res_s),
    .branch_shutter_out      (br_s),
    .ts_unit_out             (ts_s),
    .guide_light_out         (guide),
    .laser_enable_out        (laser),
    .res_open_contact_out    (res_c),
    .branch_open_contact_out (br_c),
    .ts_on_contact_out       (ts_c),
    .estop_contact_out       (estop_c),
    .irq_out                 (irq)
  );

  sse_plc_model plc (
    .clk_sys_in   (clk_sys_in),
    .estop_req_in (estop_req),
    .ilk_req_in   (ilk_req),
    .ts_req_in    (ts_req),
    .bounce_in    (bounce),
    .loops_out    (loops)
  );

  // ============================================================
  // Comparison and closing
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Monitor takes the oldest note whenever a result shows up
  // Looks mid-cycle, where the design's flops have settled
  always @(negedge clk_sys_in) begin
    if (req.read && rsp.waitrequest === 1'b0) begin
      m_r = rm.pop_front();
      cmp(rsp.readdata & m_r, rq.pop_front(), "read data");
    end
    if (samp) begin
      cmp({19'h0, estop_c, laser, guide, ts_c, br_c, res_c, irq,
           (ts_s === ts_c && br_s === br_c && res_s === res_c)},
          {19'h0, oq.pop_front()}, "outputs");
    end
  end

  // ============================================================
  // Drivers
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req.address <= a;
    req.read <= rd_en;
    req.write <= !rd_en;
    req.writedata <= d;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 100);
    if (rsp.waitrequest !== 1'b0) begin
      fails++;
      $display("unexpected at %0t: bus answer missing", $time);
    end
    // Access completes at the rising edge that samples the low answer
    @(posedge clk_sys_in);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e & m);
    rm.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  // Expected contacts from control word, run state, interlock and selects
  task automatic chk(input logic [7:0] c, input logic run, input logic ilk, input logic [2:0] ts,
                     input logic irq_e);
    logic on;
    on = run & ilk;
    oq.push_back({run, c[7] & on, c[6] & on, (run & c[5]) ? ts : 3'h0, c[4:1] & {4{on}},
                  c[0] & on, irq_e, 1'b1});
    @(posedge clk_sys_in);
    samp <= 1'b1;
    @(posedge clk_sys_in);
    samp <= 1'b0;
  endtask

  task automatic loop_set(input logic e, input logic i, input logic [2:0] ts);
    @(posedge clk_sys_in);
    estop_req <= e;
    ilk_req <= i;
    ts_req <= ts;
    bounce <= 2'($random(seed));
    repeat (SETTLE) @(posedge clk_sys_in);
  endtask

  // ============================================================
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #(5 * 20000);
    fails++;
    $display("unexpected at %0t: timeout", $time);
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(8'h00, 32'h0, 32'hffffffff);
    rd(8'h10, 32'h0, 32'hffffffff);
    rd(8'h08, 32'h0, 32'h600);
    rd(8'h14, 32'h0, 32'hffffffff);
    chk(8'h00, 1'b0, 1'b0, 3'h0, 1'b0);
    $display("test reset done");
    wr(8'h10, 32'h7);
    loop_set(1'b1, 1'b1, 3'h0);
    rd(8'h0c, 32'h4, 32'h4);
    rd(8'h08, 32'h200, 32'h700);
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h600, 32'h700);
    wr(8'h00, 32'hffffffdf);
    wr(8'h08, 32'h0);
    rd(8'h00, 32'hdf, 32'hffffffff);
    rd(8'h08, 32'h600, 32'h600);
    chk(8'hdf, 1'b1, 1'b1, 3'h0, 1'b0);
    $display("test run done");
    wr(8'h00, 32'hff);
    repeat (4) begin
      t = 3'($random(seed)) | 3'h1;
      loop_set(1'b1, 1'b1, t);
      chk(8'hff, 1'b1, 1'b1, t, 1'b0);
    end
    wr(8'h00, 32'hdf);
    chk(8'hdf, 1'b1, 1'b1, t, 1'b0);
    wr(8'h00, 32'hff);
    $display("test timesharing done");
    loop_set(1'b1, 1'b0, t);
    chk(8'hff, 1'b1, 1'b0, t, 1'b1);
    rd(8'h0c, 32'h2, 32'h7);
    rd(8'h08, 32'h700, 32'h700);
    chk(8'hff, 1'b1, 1'b0, t, 1'b0);
    loop_set(1'b1, 1'b1, t);
    chk(8'hff, 1'b1, 1'b1, t, 1'b0);
    $display("test interlock done");
    @(posedge clk_sys_in);
    estop_req <= 1'b0;
    bounce <= 2'h0;
    repeat (3) @(posedge clk_sys_in);
    estop_req <= 1'b1;
    repeat (SETTLE) @(posedge clk_sys_in);
    chk(8'hff, 1'b1, 1'b1, t, 1'b0);
    rd(8'h0c, 32'h0, 32'h7);
    $display("test glitch done");
    loop_set(1'b0, 1'b1, t);
    chk(8'hff, 1'b0, 1'b1, t, 1'b1);
    rd(8'h0c, 32'h1, 32'h7);
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h0, 32'h600);
    loop_set(1'b1, 1'b1, t);
    rd(8'h0c, 32'h4, 32'h7);
    rd(8'h08, 32'h200, 32'h600);
    chk(8'hff, 1'b0, 1'b1, t, 1'b0);
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h600, 32'h600);
    chk(8'hff, 1'b1, 1'b1, t, 1'b0);
    $display("test stop done");
    wr(8'h10, 32'h0);
    loop_set(1'b0, 1'b1, t);
    chk(8'hff, 1'b0, 1'b1, t, 1'b0);
    rd(8'h0c, 32'h1, 32'h7);
    $display("test mask done");
    results();
  end
endmodule
